/* src/host_port_and_modem_pin_map.v */
// host port role selection, flow control pins, interrupt pin and shared modem pins
`timescale 1ns/1ps
`include "pin_map_defs.vh"
// Functional notes
// - strap high selects i2c target, low spi
// - addr1 pin: spi data in, or address
// - spi data out driven only while transmitting
// - sda open drain in i2c, ignored in spi
// - one clock pin serves both host ports
// - clear to send shown in status bit 4
// - clear to send gates transfer only if enabled
// - interrupt open drain, only enabled sources
// - pin, error, data, space, modem events interrupt
// - reset pin active low resets logic
// - control bit 1 drives request low
// - eight pins: gpio or modem, b low half
// - io control bit 2 selects modem function
// - request high after reset, auto when enabled
// - addr0 pin: spi chip select or address
module host_port_and_modem_pin_map (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       reset_pin_n,
  input  wire       host_sel_strap,
  input  wire       link_clk_pin,
  input  wire       serial_in_or_addr1,
  input  wire       chip_select_or_addr0,
  output wire       spi_out_pin,
  output wire       spi_out_oe_n,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe_n,
  input  wire       irq_in,
  output wire       irq_out,
  output wire       irq_oe_n,
  input  wire       clear_to_send_a_n,
  input  wire       clear_to_send_b_n,
  output wire       request_to_send_a_n,
  output wire       request_to_send_b_n,
  input  wire [7:0] shared_pin_in,
  output wire [7:0] shared_pin_out,
  output wire [7:0] shared_pin_oe_n,
  output wire       host_is_i2c,
  output wire [1:0] i2c_addr_sel,
  output wire       spi_selected,
  output wire       spi_data_in,
  output wire       spi_clk_rise,
  output wire       spi_clk_fall,
  output wire       i2c_clk_level,
  output wire       i2c_clk_rise,
  output wire       i2c_clk_fall,
  output wire       i2c_data_level,
  input  wire       i2c_data_pull_low,
  input  wire       spi_tx_data,
  input  wire       spi_tx_active,
  output wire       logic_reset,
  output wire       irq_line_low,
  input  wire [7:0] io_control_reg,
  input  wire [7:0] gpio_dir,
  input  wire [7:0] gpio_out_val,
  input  wire [7:0] gpio_int_enable,
  input  wire       gpio_state_read,
  output wire [7:0] gpio_state,
  output wire [7:0] gpio_change,
  input  wire [7:0] modem_control_reg_a,
  input  wire [7:0] modem_control_reg_b,
  input  wire [7:0] enhanced_feature_reg_a,
  input  wire [7:0] enhanced_feature_reg_b,
  input  wire [7:0] interrupt_enable_reg_a,
  input  wire [7:0] interrupt_enable_reg_b,
  input  wire       modem_status_read_a,
  input  wire       modem_status_read_b,
  output wire [7:0] modem_status_reg_a,
  output wire [7:0] modem_status_reg_b,
  output wire       tx_allowed_a,
  output wire       tx_allowed_b,
  input  wire       rx_room_a,
  input  wire       rx_room_b,
  input  wire       rx_avail_a,
  input  wire       rx_avail_b,
  input  wire       tx_space_a,
  input  wire       tx_space_b,
  input  wire       rx_error_a,
  input  wire       rx_error_b
);
  localparam NPIN = 8;

  wire            reset_pin_s;
  wire            strap_s;
  wire            link_clk_s;
  wire            si_s;
  wire            cs_s;
  wire            sda_s;
  wire            irq_s;
  wire            cts_a_s;
  wire            cts_b_s;
  wire [NPIN-1:0] pins_s;
  wire            rst;
  wire            modem_mode;
  wire [7:0]      msr_a;
  wire [7:0]      msr_b;
  wire            modem_evt_a;
  wire            modem_evt_b;

  reg             host_is_i2c_ff;
  reg             link_clk_d_ff;
  reg [1:0]       addr_sel_ff;
  reg             spi_sel_ff;
  reg             spi_in_ff;
  reg             spi_rise_ff;
  reg             spi_fall_ff;
  reg             i2c_lvl_ff;
  reg             i2c_rise_ff;
  reg             i2c_fall_ff;
  reg             i2c_data_ff;
  reg             so_out_ff;
  reg             so_oe_n_ff;
  reg             sda_oe_n_ff;
  reg             irq_oe_n_ff;
  reg             irq_low_ff;
  reg [NPIN-1:0]  gpio_state_ff;
  reg [NPIN-1:0]  gpio_change_ff;
  reg [NPIN-1:0]  nxt_gpio_change;
  reg             nxt_irq;
  reg             clk_rise;
  reg             clk_fall;
  reg             strap_meta_ff;
  reg             strap_sync_ff;

  // strap synchroniser has no reset so the strap is settled before srst releases
  always @(posedge sys_clk) begin
    strap_meta_ff <= host_sel_strap;
    strap_sync_ff <= strap_meta_ff;
  end

  assign strap_s = strap_sync_ff;

  // pin inputs pass two flip-flops before any logic reads them
  sync_stage #(.WIDTH(1), .RST_VAL(1)) u_sync_reset (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       (reset_pin_n),
    .q       (reset_pin_s)
  );

  sync_stage #(.WIDTH(7), .RST_VAL(7'h7F)) u_sync_host (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       ({link_clk_pin, serial_in_or_addr1, chip_select_or_addr0,
                sda_in, irq_in, clear_to_send_a_n, clear_to_send_b_n}),
    .q       ({link_clk_s, si_s, cs_s, sda_s, irq_s, cts_a_s, cts_b_s})
  );

  sync_stage #(.WIDTH(NPIN), .RST_VAL(255)) u_sync_pins (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       (shared_pin_in),
    .q       (pins_s)
  );

  assign rst        = srst | ~reset_pin_s;
  assign modem_mode = io_control_reg[`IOC_MODEM];

  // link clock edges found from the synchronised level
  always @* begin
    clk_rise = link_clk_s & ~link_clk_d_ff;
    clk_fall = ~link_clk_s & link_clk_d_ff;
  end

  // interrupt sources gated by their enables
  always @* begin
    nxt_gpio_change = gpio_state_read ? {NPIN{1'h0}} : gpio_change_ff;
    nxt_gpio_change = nxt_gpio_change | ((pins_s ^ gpio_state_ff) & ~gpio_dir); // set wins
    nxt_irq = (|(gpio_change_ff & gpio_int_enable))
            | (interrupt_enable_reg_a[`IER_RX_DATA]  & rx_avail_a)
            | (interrupt_enable_reg_a[`IER_TX_SPACE] & tx_space_a)
            | (interrupt_enable_reg_a[`IER_RX_ERROR] & rx_error_a)
            | (interrupt_enable_reg_a[`IER_MODEM]    & modem_evt_a)
            | (interrupt_enable_reg_b[`IER_RX_DATA]  & rx_avail_b)
            | (interrupt_enable_reg_b[`IER_TX_SPACE] & tx_space_b)
            | (interrupt_enable_reg_b[`IER_RX_ERROR] & rx_error_b)
            | (interrupt_enable_reg_b[`IER_MODEM]    & modem_evt_b);
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      host_is_i2c_ff <= strap_s;
      link_clk_d_ff  <= link_clk_s; // no false edge on release
      addr_sel_ff    <= 2'h0;
      spi_sel_ff     <= 1'h0;
      spi_in_ff      <= 1'h0;
      spi_rise_ff    <= 1'h0;
      spi_fall_ff    <= 1'h0;
      i2c_lvl_ff     <= 1'h1;
      i2c_rise_ff    <= 1'h0;
      i2c_fall_ff    <= 1'h0;
      i2c_data_ff    <= 1'h1;
      so_out_ff      <= 1'h0;
      so_oe_n_ff     <= 1'h1;
      sda_oe_n_ff    <= 1'h1;
      irq_oe_n_ff    <= 1'h1;
      irq_low_ff     <= 1'h0;
      gpio_state_ff  <= pins_s; // no false change flags on release
      gpio_change_ff <= {NPIN{1'h0}};
    end else begin
      link_clk_d_ff  <= link_clk_s;
      if (host_is_i2c_ff) begin
        addr_sel_ff    <= {si_s, cs_s};
        spi_sel_ff     <= 1'h0;
        spi_in_ff      <= 1'h0;
        spi_rise_ff    <= 1'h0;
        spi_fall_ff    <= 1'h0;
        i2c_lvl_ff     <= link_clk_s;
        i2c_rise_ff    <= clk_rise;
        i2c_fall_ff    <= clk_fall;
        i2c_data_ff    <= sda_s;
        so_out_ff      <= 1'h0;
        so_oe_n_ff     <= 1'h1;
        sda_oe_n_ff    <= ~i2c_data_pull_low;
      end else begin
        addr_sel_ff    <= 2'h0;
        spi_sel_ff     <= ~cs_s;
        spi_in_ff      <= si_s;
        spi_rise_ff    <= clk_rise & ~cs_s;
        spi_fall_ff    <= clk_fall & ~cs_s;
        i2c_lvl_ff     <= 1'h1;
        i2c_rise_ff    <= 1'h0;
        i2c_fall_ff    <= 1'h0;
        i2c_data_ff    <= 1'h1;
        so_out_ff      <= spi_tx_data;
        so_oe_n_ff     <= ~(spi_tx_active & ~cs_s);
        sda_oe_n_ff    <= 1'h1;
      end
      irq_oe_n_ff    <= ~nxt_irq;
      irq_low_ff     <= ~irq_s;
      gpio_state_ff  <= pins_s;
      gpio_change_ff <= nxt_gpio_change;
    end
  end

  // channel b owns pins 0 to 3, channel a pins 4 to 7
  modem_pin_group u_chan_b (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .modem_mode  (modem_mode),
    .gpio_dir    (gpio_dir[`CHB_BASE+3:`CHB_BASE]),
    .gpio_out    (gpio_out_val[`CHB_BASE+3:`CHB_BASE]),
    .pin_in      (pins_s[`CHB_BASE+3:`CHB_BASE]),
    .cts_n       (cts_b_s),
    .modem_control_reg         (modem_control_reg_b),
    .enhanced_feature_reg         (enhanced_feature_reg_b),
    .msr_read    (modem_status_read_b),
    .rx_room     (rx_room_b),
    .pin_out     (shared_pin_out[`CHB_BASE+3:`CHB_BASE]),
    .pin_oe_n    (shared_pin_oe_n[`CHB_BASE+3:`CHB_BASE]),
    .rts_n       (request_to_send_b_n),
    .tx_allowed  (tx_allowed_b),
    .modem_status_reg         (msr_b),
    .modem_event (modem_evt_b)
  );

  modem_pin_group u_chan_a (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .modem_mode  (modem_mode),
    .gpio_dir    (gpio_dir[`CHA_BASE+3:`CHA_BASE]),
    .gpio_out    (gpio_out_val[`CHA_BASE+3:`CHA_BASE]),
    .pin_in      (pins_s[`CHA_BASE+3:`CHA_BASE]),
    .cts_n       (cts_a_s),
    .modem_control_reg         (modem_control_reg_a),
    .enhanced_feature_reg         (enhanced_feature_reg_a),
    .msr_read    (modem_status_read_a),
    .rx_room     (rx_room_a),
    .pin_out     (shared_pin_out[`CHA_BASE+3:`CHA_BASE]),
    .pin_oe_n    (shared_pin_oe_n[`CHA_BASE+3:`CHA_BASE]),
    .rts_n       (request_to_send_a_n),
    .tx_allowed  (tx_allowed_a),
    .modem_status_reg         (msr_a),
    .modem_event (modem_evt_a)
  );

  assign host_is_i2c        = host_is_i2c_ff;
  assign i2c_addr_sel       = addr_sel_ff;
  assign spi_selected       = spi_sel_ff;
  assign spi_data_in        = spi_in_ff;
  assign spi_clk_rise       = spi_rise_ff;
  assign spi_clk_fall       = spi_fall_ff;
  assign i2c_clk_level      = i2c_lvl_ff;
  assign i2c_clk_rise       = i2c_rise_ff;
  assign i2c_clk_fall       = i2c_fall_ff;
  assign i2c_data_level     = i2c_data_ff;
  assign spi_out_pin        = so_out_ff;
  assign spi_out_oe_n       = so_oe_n_ff;
  assign sda_out            = 1'h0;
  assign sda_oe_n           = sda_oe_n_ff;
  assign irq_out            = 1'h0;
  assign irq_oe_n           = irq_oe_n_ff;
  assign irq_line_low       = irq_low_ff;
  assign logic_reset        = rst;
  assign gpio_state         = gpio_state_ff;
  assign gpio_change        = gpio_change_ff;
  assign modem_status_reg_a = msr_a;
  assign modem_status_reg_b = msr_b;
endmodule

/* src/pin_map_defs.vh */
// bit positions and fixed values shared by the pin map files
`ifndef PIN_MAP_DEFS_VH
`define PIN_MAP_DEFS_VH

// modem status register bits
`define MSR_DCTS      0
`define MSR_DDSR      1
`define MSR_TERI      2
`define MSR_DCD       3
`define MSR_CTS       4
`define MSR_DSR       5
`define MSR_RI        6
`define MSR_CD        7

// modem control register bits
`define MCR_DTR       0
`define MCR_RTS       1

// enhanced feature register bits
`define EFR_AUTO_RTS  6
`define EFR_AUTO_CTS  7

// interrupt enable register bits
`define IER_RX_DATA   0
`define IER_TX_SPACE  1
`define IER_RX_ERROR  2
`define IER_MODEM     3

// io control register bits
`define IOC_MODEM     2

// role of each pin inside a four-pin modem group
`define GRP_DSR       0
`define GRP_DTR       1
`define GRP_CD        2
`define GRP_RI        3

// pin group offsets
`define CHB_BASE      0
`define CHA_BASE      4

`endif

/* src/sync_stage.v */
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module sync_stage #(
  parameter WIDTH    = 1,
  parameter RST_VAL  = 0
) (
  input  wire             sys_clk,
  input  wire             srst,
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] q_ff;

  always @(posedge sys_clk) begin
    if (srst) begin
      meta_ff <= RST_VAL[WIDTH-1:0];
      q_ff    <= RST_VAL[WIDTH-1:0];
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

/* src/modem_pin_group.v */
// one channel: four shared pins, clear/request to send and modem status
`timescale 1ns/1ps
`include "pin_map_defs.vh"
module modem_pin_group (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire       modem_mode,
  input  wire [3:0] gpio_dir,
  input  wire [3:0] gpio_out,
  input  wire [3:0] pin_in,
  input  wire       cts_n,
  input  wire [7:0] modem_control_reg,
  input  wire [7:0] enhanced_feature_reg,
  input  wire       msr_read,
  input  wire       rx_room,
  output wire [3:0] pin_out,
  output wire [3:0] pin_oe_n,
  output wire       rts_n,
  output wire       tx_allowed,
  output wire [7:0] modem_status_reg,
  output wire       modem_event
);
  reg [3:0] pin_out_ff;
  reg [3:0] pin_oe_n_ff;
  reg       rts_n_ff;
  reg       tx_allowed_ff;
  reg [3:0] state_ff;
  reg [3:0] delta_ff;
  reg [3:0] nxt_state;
  reg [3:0] nxt_delta;
  reg [3:0] nxt_out;
  reg [3:0] nxt_oe_n;
  reg       cts_on;

  always @* begin
    cts_on = ~cts_n;
    nxt_state[0] = cts_on;
    nxt_state[1] = modem_mode & ~pin_in[`GRP_DSR];
    nxt_state[2] = modem_mode & ~pin_in[`GRP_RI];
    nxt_state[3] = modem_mode & ~pin_in[`GRP_CD];
    nxt_delta    = msr_read ? 4'h0 : delta_ff;
    nxt_delta[0] = nxt_delta[0] | (nxt_state[0] ^ state_ff[0]);
    nxt_delta[1] = nxt_delta[1] | (nxt_state[1] ^ state_ff[1]);
    nxt_delta[2] = nxt_delta[2] | (state_ff[2] & ~nxt_state[2]);
    nxt_delta[3] = nxt_delta[3] | (nxt_state[3] ^ state_ff[3]);
    if (modem_mode) begin
      nxt_out  = 4'h0;
      nxt_oe_n = 4'hF;
      nxt_out[`GRP_DTR]  = ~modem_control_reg[`MCR_DTR];
      nxt_oe_n[`GRP_DTR] = 1'h0;
    end else begin
      nxt_out  = gpio_out;
      nxt_oe_n = ~gpio_dir;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      pin_out_ff    <= 4'h0;
      pin_oe_n_ff   <= 4'hF;
      rts_n_ff      <= 1'h1;
      tx_allowed_ff <= 1'h0;
      state_ff      <= 4'h0;
      delta_ff      <= 4'h0;
    end else begin
      pin_out_ff    <= nxt_out;
      pin_oe_n_ff   <= nxt_oe_n;
      rts_n_ff      <= ~(modem_control_reg[`MCR_RTS] | (enhanced_feature_reg[`EFR_AUTO_RTS] & rx_room));
      tx_allowed_ff <= ~enhanced_feature_reg[`EFR_AUTO_CTS] | cts_on;
      state_ff      <= nxt_state;
      delta_ff      <= nxt_delta; // set wins over the read clear
    end
  end

  assign pin_out     = pin_out_ff;
  assign pin_oe_n    = pin_oe_n_ff;
  assign rts_n       = rts_n_ff;
  assign tx_allowed  = tx_allowed_ff;
  assign modem_status_reg         = {state_ff[3], state_ff[2], state_ff[1], state_ff[0], delta_ff};
  assign modem_event = |delta_ff;
endmodule

/* test/pin_map_chk.sv */
// assertion checker for the host port and modem pin map
`timescale 1ns/1ps
module pin_map_chk (
  input logic       sys_clk,
  input logic       srst,
  input logic       reset_pin_n,
  input logic       logic_reset,
  input logic       host_is_i2c,
  input logic [1:0] i2c_addr_sel,
  input logic       spi_selected,
  input logic       spi_clk_rise,
  input logic       i2c_clk_rise,
  input logic       spi_tx_active,
  input logic       spi_out_oe_n,
  input logic       i2c_data_pull_low,
  input logic       sda_oe_n,
  input logic       sda_out,
  input logic       irq_oe_n,
  input logic       irq_out,
  input logic       rx_avail_a,
  input logic [7:0] interrupt_enable_reg_a,
  input logic [7:0] interrupt_enable_reg_b,
  input logic [7:0] gpio_int_enable,
  input logic       clear_to_send_a_n,
  input logic [7:0] modem_status_reg_a,
  input logic [7:0] enhanced_feature_reg_a,
  input logic [7:0] modem_control_reg_a,
  input logic       rx_room_a,
  input logic       request_to_send_a_n,
  input logic       tx_allowed_a,
  input logic [7:0] io_control_reg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (logic_reset);
  sequence s_cts_active;
    !clear_to_send_a_n [*4];
  endsequence
  sequence s_cts_blocked;
    (enhanced_feature_reg_a[7] && clear_to_send_a_n) [*4];
  endsequence
  property p_roles;
    host_is_i2c ? (!spi_selected && !spi_clk_rise) : (i2c_addr_sel == 2'h0 && !i2c_clk_rise);
  endproperty
  a_roles: assert property (p_roles) else $error("host port role mixed");
  property p_spi_out;
    !spi_out_oe_n |-> $past(spi_tx_active);
  endproperty
  a_spi_out: assert property (p_spi_out) else $error("data out driven while idle");
  property p_sda;
    !sda_oe_n |-> host_is_i2c && $past(i2c_data_pull_low) && sda_out == 1'h0;
  endproperty
  a_sda: assert property (p_sda) else $error("sda driven wrongly");
  property p_spi_clk;
    spi_clk_rise |-> spi_selected;
  endproperty
  a_spi_clk: assert property (p_spi_clk) else $error("clock edge without select");
  property p_cts_status;
    s_cts_active |=> modem_status_reg_a[4];
  endproperty
  a_cts_status: assert property (p_cts_status) else $error("clear to send not in status");
  property p_cts_gate;
    s_cts_blocked |=> !tx_allowed_a;
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("transmit not held back");
  property p_cts_free;
    (!logic_reset && !enhanced_feature_reg_a[7]) |=> tx_allowed_a;
  endproperty
  a_cts_free: assert property (p_cts_free) else $error("transmit gated without auto mode");
  property p_irq_src;
    (rx_avail_a && interrupt_enable_reg_a[0]) |=> !irq_oe_n && irq_out == 1'h0;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("enabled source gave no interrupt");
  property p_irq_mask;
    !irq_oe_n |-> $past(interrupt_enable_reg_a) != 8'h00 || $past(interrupt_enable_reg_b) != 8'h00
      || $past(gpio_int_enable) != 8'h00;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt with all sources masked");
  property p_rts_low;
    (modem_control_reg_a[1] || (enhanced_feature_reg_a[6] && rx_room_a)) |=> !request_to_send_a_n;
  endproperty
  a_rts_low: assert property (p_rts_low) else $error("request to send not low");
  property p_rts_high;
    (!modem_control_reg_a[1] && !enhanced_feature_reg_a[6]) |=> request_to_send_a_n;
  endproperty
  a_rts_high: assert property (p_rts_high) else $error("request to send low unasked");
  property p_gpio_mode;
    !io_control_reg[2] [*2] |=> modem_status_reg_a[7:5] == 3'h0;
  endproperty
  a_gpio_mode: assert property (p_gpio_mode) else $error("modem inputs shown in gpio mode");
  property p_reset_pin;
    disable iff (srst) !reset_pin_n [*3] |=> logic_reset;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");
endmodule
bind host_port_and_modem_pin_map pin_map_chk pin_map_chk_inst (.*);

/* test/host_model.sv */
// host controller model driving serial clock, select, data and sda pull
`timescale 1ns/1ps
module host_model (
  output logic link_clk_pin,
  output logic serial_in_or_addr1,
  output logic chip_select_or_addr0,
  output logic sda_pull
);
  initial begin
    link_clk_pin = 1'h0;
    serial_in_or_addr1 = 1'h0;
    chip_select_or_addr0 = 1'h1;
    sda_pull = 1'h0;
  end
  task automatic clocks(input int n);
    repeat (n) begin
      #62.5 link_clk_pin = ~link_clk_pin;
      #62.5 link_clk_pin = ~link_clk_pin;
    end
  endtask
  task automatic spi_frame(input logic [7:0] b);
    #1.3 chip_select_or_addr0 = 1'h0;
    for (int i = 7; i >= 0; i--) begin
      serial_in_or_addr1 = b[i];
      clocks(1);
    end
    #62.5 chip_select_or_addr0 = 1'h1;
    serial_in_or_addr1 = ~serial_in_or_addr1;
  endtask
  task automatic pins(input logic a1, input logic a0);
    serial_in_or_addr1 = a1;
    chip_select_or_addr0 = a0;
    link_clk_pin = 1'h1;
  endtask
  task automatic select(input logic v);
    chip_select_or_addr0 = v;
  endtask
  task automatic sda(input logic v);
    sda_pull = v;
  endtask
endmodule

/* test/tb.sv */
// self-checking bench for the host port and modem pin map
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'h0, srst = 1'h1, reset_pin_n = 1'h1, host_sel_strap = 1'h0;
  logic clear_to_send_a_n = 1'h1, clear_to_send_b_n = 1'h1, i2c_data_pull_low = 1'h0, spi_tx_active = 1'h0;
  logic gpio_state_read = 1'h0, modem_status_read_a = 1'h0, rx_room_a = 1'h0, rx_avail_b = 1'h0;
  logic [7:0] io_control_reg = 8'h00, gpio_dir = 8'h00, gpio_out_val = 8'h00, gpio_int_enable = 8'h00;
  logic [7:0] modem_control_reg_a = 8'h00, modem_control_reg_b = 8'h00, ext_pins = 8'hFF;
  logic [7:0] enhanced_feature_reg_a = 8'h00, enhanced_feature_reg_b = 8'h00, shifted = 8'h00;
  logic [7:0] interrupt_enable_reg_a = 8'h00, interrupt_enable_reg_b = 8'h00;
  logic [2:0] src_a = 3'h0;
  wire spi_tx_data = 1'h1, modem_status_read_b = 1'h0, rx_room_b = 1'h0, tx_space_b = 1'h0, rx_error_b = 1'h0;
  wire rx_avail_a = src_a[0], tx_space_a = src_a[1], rx_error_a = src_a[2];
  wire link_clk_pin, serial_in_or_addr1, chip_select_or_addr0, sda_pull;
  wire spi_out_pin, spi_out_oe_n, sda_out, sda_oe_n, irq_out, irq_oe_n, request_to_send_a_n, request_to_send_b_n;
  wire host_is_i2c, spi_selected, spi_data_in, spi_clk_rise, spi_clk_fall, i2c_clk_level, i2c_clk_rise;
  wire i2c_clk_fall, i2c_data_level, logic_reset, irq_line_low, tx_allowed_a, tx_allowed_b;
  wire [1:0] i2c_addr_sel;
  wire [7:0] gpio_state, gpio_change, modem_status_reg_a, modem_status_reg_b;
  wire [7:0] shared_pin_out, shared_pin_oe_n;
  wire sda_in = ~(sda_pull | ~sda_oe_n);
  wire irq_in = irq_oe_n | irq_out;
  wire [7:0] shared_pin_in = (~shared_pin_oe_n & shared_pin_out) | (shared_pin_oe_n & ext_pins);
  int miscompares = 0, tests_run = 0, rises = 0, falls = 0, i2c_rises = 0;
  host_port_and_modem_pin_map host_port_and_modem_pin_map_inst (.*);
  host_model host_model_inst (.*);
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (spi_clk_rise === 1'h1) begin
      rises <= rises + 1;
      shifted <= {shifted[6:0], spi_data_in};
    end
    if (spi_clk_fall === 1'h1) falls <= falls + 1;
    if (i2c_clk_rise === 1'h1) i2c_rises <= i2c_rises + 1;
  end
  task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  task look(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task summarize;
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task t_reset;
    chk("rts_a", request_to_send_a_n, 1'h1);
    chk("rts_b", request_to_send_b_n, 1'h1);
    chk("pin_oe", shared_pin_oe_n, 8'hFF);
    chk("i2c_sel", host_is_i2c, 1'h0);
  endtask
  task t_spi;
    rises = 0;
    falls = 0;
    host_model_inst.spi_frame(8'hA5);
    look(4);
    chk("spi_bits", rises[7:0], 8'h08);
    chk("spi_falls", falls[7:0], 8'h08);
    chk("spi_byte", shifted, 8'hA5);
    chk("addr_sel", i2c_addr_sel, 2'h0);
    rises = 0;
    host_model_inst.clocks(3);
    look(4);
    chk("idle_clk", rises[7:0], 8'h00);
    host_model_inst.select(1'h0);
    @(posedge sys_clk) spi_tx_active <= 1'h1;
    look(3);
    chk("so_on", spi_out_oe_n, 1'h0);
    chk("so_data", spi_out_pin, 1'h1);
    chk("spi_sel", spi_selected, 1'h1);
    @(posedge sys_clk) spi_tx_active <= 1'h0;
    look(1);
    chk("so_off", spi_out_oe_n, 1'h1);
    host_model_inst.select(1'h1);
    host_model_inst.sda(1'h1);
    @(posedge sys_clk) i2c_data_pull_low <= 1'h1;
    look(4);
    chk("sda_oe", sda_oe_n, 1'h1);
    chk("sda_lvl", i2c_data_level, 1'h1);
    host_model_inst.sda(1'h0);
    @(posedge sys_clk) i2c_data_pull_low <= 1'h0;
  endtask
  task t_flow;
    @(posedge sys_clk) clear_to_send_a_n <= 1'h0;
    clear_to_send_b_n <= 1'h0;
    look(4);
    chk("msr_a", modem_status_reg_a & 8'h11, 8'h11);
    chk("msr_b", modem_status_reg_b & 8'h10, 8'h10);
    @(posedge sys_clk) modem_status_read_a <= 1'h1;
    @(posedge sys_clk) modem_status_read_a <= 1'h0;
    look(1);
    chk("msr_clr", modem_status_reg_a & 8'h11, 8'h10);
    @(posedge sys_clk) clear_to_send_a_n <= 1'h1;
    look(4);
    chk("tx_free", tx_allowed_a, 1'h1);
    chk("tx_free_b", tx_allowed_b, 1'h1);
    @(posedge sys_clk) enhanced_feature_reg_a <= 8'h80;
    look(1);
    chk("tx_hold", tx_allowed_a, 1'h0);
    @(posedge sys_clk) clear_to_send_a_n <= 1'h0;
    look(4);
    chk("tx_go", tx_allowed_a, 1'h1);
    @(posedge sys_clk) modem_control_reg_b <= 8'h02;
    look(1);
    chk("rts_b", request_to_send_b_n, 1'h0);
    chk("rts_a", request_to_send_a_n, 1'h1);
    @(posedge sys_clk) modem_control_reg_b <= 8'h00;
    enhanced_feature_reg_a <= 8'h40;
    rx_room_a <= 1'h1;
    look(1);
    chk("auto_rts", request_to_send_a_n, 1'h0);
    @(posedge sys_clk) rx_room_a <= 1'h0;
    look(1);
    chk("rts_full", request_to_send_a_n, 1'h1);
    enhanced_feature_reg_a <= 8'h00;
  endtask
  task automatic t_irq;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk) src_a <= 3'h1 << i;
      look(1);
      chk("irq_mask", irq_oe_n, 1'h1);
      @(posedge sys_clk) interrupt_enable_reg_a <= 8'h01 << i;
      look(1);
      chk("irq_src", irq_oe_n, 1'h0);
      look(3);
      chk("irq_line", irq_line_low, 1'h1);
      @(posedge sys_clk) interrupt_enable_reg_a <= 8'h00;
      src_a <= 3'h0;
    end
    @(posedge sys_clk) rx_avail_b <= 1'h1;
    interrupt_enable_reg_b <= 8'h01;
    look(1);
    chk("irq_b", irq_oe_n, 1'h0);
    @(posedge sys_clk) interrupt_enable_reg_b <= 8'h00;
    gpio_int_enable <= 8'h01;
    ext_pins <= 8'hFE;
    look(5);
    chk("irq_pin", irq_oe_n, 1'h0);
    chk("gpio_state", gpio_state, 8'hFE);
    chk("gpio_chg", gpio_change, 8'h01);
    @(posedge sys_clk) gpio_state_read <= 1'h1;
    @(posedge sys_clk) gpio_state_read <= 1'h0;
    look(2);
    chk("irq_read", irq_oe_n, 1'h1);
    chk("gpio_clr", gpio_change, 8'h00);
    gpio_int_enable <= 8'h00;
  endtask
  task t_gpio;
    @(posedge sys_clk) gpio_dir <= 8'h0F;
    gpio_out_val <= 8'h05;
    look(1);
    chk("gpio_oe", shared_pin_oe_n, 8'hF0);
    chk("gpio_out", shared_pin_out & 8'h0F, 8'h05);
    chk("gpio_msr", modem_status_reg_a & 8'hE0, 8'h00);
    @(posedge sys_clk) gpio_dir <= 8'h00;
    ext_pins <= 8'h00;
    io_control_reg <= 8'h04;
    look(4);
    chk("dtr_oe", shared_pin_oe_n & 8'h22, 8'h00);
    chk("dtr_out", shared_pin_out & 8'h22, 8'h22);
    chk("dsr_a", modem_status_reg_a & 8'h20, 8'h20);
    chk("dsr_b", modem_status_reg_b & 8'h20, 8'h20);
  endtask
  task t_i2c;
    @(posedge sys_clk) host_sel_strap <= 1'h1;
    reset_pin_n <= 1'h0;
    look(4);
    chk("pin_reset", logic_reset, 1'h1);
    @(posedge sys_clk) reset_pin_n <= 1'h1;
    look(4);
    chk("i2c_sel", host_is_i2c, 1'h1);
    host_model_inst.pins(1'h1, 1'h0);
    look(4);
    chk("addr_sel", i2c_addr_sel, 2'h2);
    i2c_rises = 0;
    rises = 0;
    host_model_inst.clocks(3);
    look(4);
    chk("scl_edges", i2c_rises[7:0], 8'h03);
    chk("sclk_edges", rises[7:0], 8'h00);
    chk("scl_lvl", i2c_clk_level, 1'h1);
    @(posedge sys_clk) i2c_data_pull_low <= 1'h1;
    look(1);
    chk("sda_oe", sda_oe_n, 1'h0);
    look(3);
    chk("sda_lvl", i2c_data_level, 1'h0);
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'h0;
    look(1);
    t_reset;
    t_spi;
    t_flow;
    t_irq;
    t_gpio;
    t_i2c;
    summarize;
  end
  initial begin
    #200000;
    miscompares++;
    summarize;
  end
endmodule
